//--- sbrg_defs.vh
// Purpose: Constants for the serial channel 0 bit-rate generator.
// Assumes: 8-bit register port, 10 MHz system clock.
// Notes:   Offsets are the special function register addresses.
`ifndef SBRG_DEFS_VH
`define SBRG_DEFS_VH
`define SBRG_ADDR_RELOAD_LOW   8'hAA
`define SBRG_ADDR_RELOAD_HIGH  8'hBA
`define SBRG_ADDR_CONV_CTRL    8'hD8
`define SBRG_ADDR_POWER_CTRL   8'h87
`define SBRG_ADDR_SERIAL_MODE  8'h98
`define SBRG_RST_RELOAD_LOW    8'hD9
`define SBRG_RST_RELOAD_HIGH   2'h3
`define SBRG_BIT_BAUD_SEL      7
`define SBRG_BIT_DOUBLING      7
`define SBRG_BIT_MODE_HI       7
`define SBRG_BIT_MODE_LO       6
`define SBRG_T1_DIV            5'h00
`define SBRG_MODE2_DIV         2'h0
`define SBRG_MODE_FIXED2       2'h2
`endif

//--- sbrg_reload_counter.v
// Purpose: Free-running 10-bit reload counter of the dedicated generator.
// Assumes: Advance pulse arrives every second clock.
// Notes:   Overflow is a one-cycle pulse in the cycle the counter wraps.
module sbrg_reload_counter (
	input  wire       clk_sys_i,    // System clock.
	input  wire       rst_b_i,      // Asynchronous reset, active low.
	input  wire       run_i,        // Counter runs while high.
	input  wire       advance_i,    // Half-rate advance pulse.
	input  wire       load_i,       // Immediate reload request.
	input  wire [9:0] reload_i,     // Reload value.
	output reg        overflow_o    // One-cycle overflow pulse.
);
	reg [9:0] count_reg;

	// A reload write wins over counting so software starts from a known phase.
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_reg  <= 10'h000;
			overflow_o <= 1'b0;
		end else begin
			overflow_o <= 1'b0;
			if (load_i) begin
				count_reg <= reload_i;
			end else if (run_i && advance_i) begin
				if (count_reg == 10'h3FF) begin
					count_reg  <= reload_i;
					overflow_o <= 1'b1;
				end else begin
					count_reg <= count_reg + 10'h001;
				end
			end
		end
	end
endmodule // sbrg_reload_counter

//--- sbrg_divider.v
// Purpose: Divides an event stream by a programmable count plus one.
// Assumes: Input events are one-cycle pulses.
// Notes:   Output pulse marks the last event of each group.
module sbrg_divider (
	input  wire       clk_sys_i,    // System clock.
	input  wire       rst_b_i,      // Asynchronous reset, active low.
	input  wire       event_i,      // Input event pulse.
	input  wire [4:0] limit_i,      // Events per output minus one.
	output reg        tick_o        // Divided pulse.
);
	reg [4:0] cnt_reg;

	// Count events and fire when the limit is reached.
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= 5'h00;
			tick_o  <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (event_i) begin
				if (cnt_reg >= limit_i) begin
					cnt_reg <= 5'h00;
					tick_o  <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 5'h01;
				end
			end
		end
	end
endmodule // sbrg_divider

//--- sbrg_baud_gen.v
// How it works
// - Select bit set routes the dedicated generator to modes 1 and 3.
// - Select bit clear uses timer 1 overflows divided by 32 over doubling.
// - Timer 1 auto-reload gives oscillator over 32, 12, 256 minus reload.
// - Any timer 1 mode is accepted as the overflow source.
// - Dedicated counter is a free 10-bit up-counter at half oscillator rate.
// - On overflow the counter reloads from low register and high bits 1:0.
// - Writing the low reload register loads the counter immediately.
// - Reset gives low reload D9 and high reload bits at one.
// - Select bit both routes the generator and starts its counter.
// - Doubling bit inserts or bypasses a divide-by-two stage.
// - Dedicated rate is oscillator times 2^doubling over 64 times 1024 minus reload.
// - Reset reloads give 4800 or 9600 bit/s at a 12 MHz oscillator.
// - Output runs at sixteen times the bit rate.
// - Mode 2 bit rate is oscillator over 64, or over 32 when doubled.
//
// Purpose: Bit-rate enable generator for serial channel 0.
// Assumes: Core writes special function registers over a plain byte port.
// Notes:   Mode 0 is clocked by the serial logic itself; its tick stays low here.
//
// Our own choice: strobed register access.
`include "sbrg_defs.vh"
module sbrg_baud_gen (
	input  wire       clk_sys_i,      // Oscillator clock.
	input  wire       rst_b_i,        // Asynchronous reset, active low.
	input  wire [7:0] addr_i,         // Register address.
	input  wire [7:0] wdata_i,        // Write data.
	input  wire       wr_i,           // Write strobe.
	input  wire       rd_i,           // Read strobe.
	output reg  [7:0] rdata_o,        // Read data, one cycle after read.
	input  wire       t1_overflow_i,  // Timer 1 overflow pulse.
	output reg        tick16_o,       // Enable at 16x bit rate.
	output reg        baud_source_select_o, // Current select bit.
	output reg        gen_overflow_o  // Dedicated counter overflow pulse.
);
	reg  [7:0] reload_low_reg;
	reg  [1:0] reload_high_reg;
	reg        baud_source_select_reg;
	reg        rate_doubling_bit_reg;
	reg  [1:0] serial_mode_reg;
	reg  [6:0] conv_other_reg;
	reg        half_phase_reg;
	reg        dbl_phase_reg;
	reg  [7:0] rdata_next;
	reg        pre_event;
	reg        tick_next;
	wire [9:0] reload_value_10bit;
	wire       gen_ovf;
	wire       t1_tick;
	wire       m2_tick;
	wire       variable_mode;
	wire       wr_low;

	assign reload_value_10bit = {reload_high_reg, reload_low_reg};
	assign wr_low = wr_i && (addr_i == `SBRG_ADDR_RELOAD_LOW);
	assign variable_mode = (serial_mode_reg == 2'h1) || (serial_mode_reg == 2'h3);

	// Register writes; the bits this block uses are stored, plus conversion control bits 6:0 for readback.
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reload_low_reg         <= `SBRG_RST_RELOAD_LOW;
			reload_high_reg        <= `SBRG_RST_RELOAD_HIGH;
			baud_source_select_reg <= 1'b0;
			rate_doubling_bit_reg  <= 1'b0;
			serial_mode_reg        <= 2'h0;
			conv_other_reg         <= 7'h00;
		end else if (wr_i) begin
			case (addr_i)
				`SBRG_ADDR_RELOAD_LOW: begin
					reload_low_reg <= wdata_i;
				end
				`SBRG_ADDR_RELOAD_HIGH: begin
					reload_high_reg <= wdata_i[1:0];
				end
				`SBRG_ADDR_CONV_CTRL: begin
					baud_source_select_reg <= wdata_i[`SBRG_BIT_BAUD_SEL];
					conv_other_reg         <= wdata_i[6:0];
				end
				`SBRG_ADDR_POWER_CTRL: begin
					rate_doubling_bit_reg <= wdata_i[`SBRG_BIT_DOUBLING];
				end
				`SBRG_ADDR_SERIAL_MODE: begin
					serial_mode_reg <= {wdata_i[`SBRG_BIT_MODE_HI], wdata_i[`SBRG_BIT_MODE_LO]};
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux; the undefined upper bits of the high reload register read as zero.
	always @* begin
		case (addr_i)
			`SBRG_ADDR_RELOAD_LOW:  rdata_next = reload_low_reg;
			`SBRG_ADDR_RELOAD_HIGH: rdata_next = {6'h00, reload_high_reg};
			`SBRG_ADDR_CONV_CTRL:   rdata_next = {baud_source_select_reg, conv_other_reg};
			`SBRG_ADDR_POWER_CTRL:  rdata_next = {rate_doubling_bit_reg, 7'h00};
			`SBRG_ADDR_SERIAL_MODE: rdata_next = {serial_mode_reg, 6'h00};
			default:                rdata_next = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rd_i ? rdata_next : 8'h00;
		end
	end

	// Half-rate phase: advances the counter and forms the mode 2 base rate.
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			half_phase_reg <= 1'b0;
		end else begin
			half_phase_reg <= ~half_phase_reg;
		end
	end

	sbrg_reload_counter u_counter (
		.clk_sys_i  (clk_sys_i),
		.rst_b_i    (rst_b_i),
		.run_i      (baud_source_select_reg),
		.advance_i  (half_phase_reg),
		.load_i     (wr_low),
		.reload_i   (wr_low ? {reload_high_reg, wdata_i} : reload_value_10bit),
		.overflow_o (gen_ovf)
	);

	// Each timer 1 overflow is already a 16x tick before doubling; this stage only retimes it.
	sbrg_divider u_t1_div (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.event_i   (t1_overflow_i),
		.limit_i   (`SBRG_T1_DIV),
		.tick_o    (t1_tick)
	);

	// Mode 2 base: every half-rate pulse, oscillator over 2, so the bit rate is over 64 or 32.
	sbrg_divider u_m2_div (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.event_i   (half_phase_reg),
		.limit_i   ({3'h0, `SBRG_MODE2_DIV}),
		.tick_o    (m2_tick)
	);

	// Source choice: generator overflow yields oscillator over 2*(1024-reload).
	always @* begin
		if (variable_mode) begin
			pre_event = baud_source_select_reg ? gen_ovf : t1_tick;
		end else if (serial_mode_reg == `SBRG_MODE_FIXED2) begin
			pre_event = m2_tick;
		end else begin
			pre_event = 1'b0;
		end
	end

	// Divide-by-two stage, bypassed when doubling is set; output is 16x rate.
	always @* begin
		tick_next = pre_event && (rate_doubling_bit_reg || dbl_phase_reg);
	end

	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dbl_phase_reg        <= 1'b0;
			tick16_o             <= 1'b0;
			baud_source_select_o <= 1'b0;
			gen_overflow_o       <= 1'b0;
		end else begin
			if (pre_event) begin
				dbl_phase_reg <= ~dbl_phase_reg;
			end
			tick16_o             <= tick_next;
			baud_source_select_o <= baud_source_select_reg;
			gen_overflow_o       <= gen_ovf;
		end
	end
endmodule // sbrg_baud_gen

//--- sbrg_t1_model.sv
// Purpose: Timer 1 stand-in giving overflow pulses.
// Assumes: Auto-reload timing, one pulse every PERIOD clocks.
// Notes:   Runs free; the generator must ignore it when not selected.
module sbrg_t1_model #(parameter int PERIOD = 3) (
	input  wire  clk_sys_i,     // Clock.
	input  wire  rst_b_i,       // Reset.
	output logic t1_overflow_o  // Overflow pulse.
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	// A single-cycle pulse on the shared clock avoids a second clock net.
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			n <= 0;
			t1_overflow_o <= 1'b0;
		end else begin
			n <= (n == PERIOD - 1) ? 0 : n + 1;
			t1_overflow_o <= (n == PERIOD - 1);
		end
	end
endmodule // sbrg_t1_model

//--- sbrg_chk_asserts.sv
// Purpose: Port checks for the bit-rate generator.
// Assumes: Shadows follow bus writes.
// Notes:   The period check skips two overflows after a reload or select write, as one may be stale.
module sbrg_chk (
	input wire       clk_sys_i,            // Clock.
	input wire       rst_b_i,              // Reset.
	input wire [7:0] addr_i,               // Address.
	input wire [7:0] wdata_i,              // Data.
	input wire       wr_i,                 // Write.
	input wire       rd_i,                 // Read.
	input wire [7:0] rdata_o,              // Read data.
	input wire       tick16_o,             // Tick.
	input wire       baud_source_select_o, // Select.
	input wire       gen_overflow_o        // Overflow.
);
	logic [7:0]  lo_sh;
	logic [1:0]  hi_sh;
	logic [1:0]  md_sh;
	logic [1:0]  cl;
	logic        sel_sh;
	logic [11:0] cnt;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	// Mirror writes; cnt measures the gap between overflows.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lo_sh <= 8'hD9;
			hi_sh <= 2'h3;
			md_sh <= 2'h0;
			sel_sh <= 1'b0;
			cl <= 2'h0;
			cnt <= 12'h000;
		end else begin
			cnt <= gen_overflow_o ? 12'h001 : cnt + 12'h001;
			if (gen_overflow_o && cl != 2'h2)
				cl <= cl + 2'h1;
			if (wr_i) begin
				case (addr_i)
				8'hAA: lo_sh <= wdata_i;
				8'hBA: hi_sh <= wdata_i[1:0];
				8'hD8: sel_sh <= wdata_i[7];
				8'h98: md_sh <= wdata_i[7:6];
				default: ;
				endcase
				if (addr_i == 8'hAA || addr_i == 8'hBA || addr_i == 8'hD8)
					cl <= 2'h0;
			end
		end
	end
	low_read_a: assert property (rd_i && addr_i == 8'hAA |=> rdata_o == lo_sh)
		else $error("low readback");
	high_read_a: assert property (rd_i && addr_i == 8'hBA |=> rdata_o[1:0] == hi_sh)
		else $error("high readback");
	sel_read_a: assert property (rd_i && addr_i == 8'hD8 |=> rdata_o[7] == sel_sh)
		else $error("select readback");
	sel_copy_a: assert property (wr_i && addr_i == 8'hD8 |-> ##2
		baud_source_select_o == $past(wdata_i[7], 2)) else $error("select copy");
	tick_pulse_a: assert property (tick16_o |=> !tick16_o)
		else $error("tick too long");
	ovf_pulse_a: assert property (gen_overflow_o |=> !gen_overflow_o)
		else $error("overflow too long");
	ovf_period_a: assert property (gen_overflow_o && cl == 2'h2 |->
		cnt == 12'(2 * (1024 - {hi_sh, lo_sh}))) else $error("overflow period");
	mode0_quiet_a: assert property ((md_sh == 2'h0) [*3] |-> !tick16_o)
		else $error("tick in mode 0");
	cover property (tick16_o);
	cover property (gen_overflow_o && cl == 2'h2);
	cover property (rd_i ##1 rdata_o != 8'h00);
endmodule // sbrg_chk

//--- testbench.sv
// Purpose: Directed bench for the channel 0 bit-rate generator.
// Assumes: 10 MHz clock; timer 1 model pulses every three clocks.
// Notes:   Counts span whole periods, so phase never shifts a count.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_sys_i = 1'b0;
	logic       rst_b_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	wire  [7:0] rdata_o;
	wire        t1_overflow_i, tick16_o, baud_source_select_o, gen_overflow_o;
	int         bad_count = 0;
	int         num_checks = 0;
	sbrg_t1_model t1_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .t1_overflow_o(t1_overflow_i));
	sbrg_baud_gen dut_u (
		.clk_sys_i            (clk_sys_i),
		.rst_b_i              (rst_b_i),
		.addr_i               (addr_i),
		.wdata_i              (wdata_i),
		.wr_i                 (wr_i),
		.rd_i                 (rd_i),
		.rdata_o              (rdata_o),
		.t1_overflow_i        (t1_overflow_i),
		.tick16_o             (tick16_o),
		.baud_source_select_o (baud_source_select_o),
		.gen_overflow_o       (gen_overflow_o)
	);
	// Free-running clock and a hang guard.
	initial forever #50 clk_sys_i = ~clk_sys_i;
	initial begin
		#5ms;
		bad_count++;
		wrap_up();
	end
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata", {4'h0, e}, {4'h0, rdata_o & m});
	endtask
	// Settle for w cycles, then count pulses over the next w cycles.
	task automatic ticks(input int w, input int e, input bit s);
		int k;
		k = 0;
		repeat (w) @(posedge clk_sys_i);
		repeat (w) begin
			@(posedge clk_sys_i);
			#1;
			if ((s ? gen_overflow_o : tick16_o) === 1'b1)
				k++;
		end
		chk(s ? "overflows" : "ticks", 12'(e), 12'(k));
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence: reset values, fixed mode, timer 1, then the reload generator.
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		rd(8'hAA, 8'hFF, 8'hD9);
		rd(8'hBA, 8'h03, 8'h03);
		rd(8'hD8, 8'h80, 8'h00);
		rd(8'h00, 8'hFF, 8'h00);
		wr(8'h98, 8'h80);
		ticks(80, 20, 0);
		wr(8'h87, 8'h80);
		ticks(80, 40, 0);
		wr(8'h98, 8'h00);
		ticks(80, 0, 0);
		wr(8'h98, 8'h40);
		ticks(48, 16, 0);
		wr(8'h87, 8'h00);
		ticks(96, 16, 0);
		wr(8'hD8, 8'h80);
		wr(8'h98, 8'hC0);
		rd(8'hD8, 8'h80, 8'h80);
		// The counter climbs from zero to its first overflow, so the settle spans that climb.
		ticks(2496, 16, 0);
		ticks(780, 10, 1);
		wr(8'h87, 8'h80);
		ticks(780, 10, 0);
		wr(8'hAA, 8'hFE);
		rd(8'hAA, 8'hFF, 8'hFE);
		ticks(40, 10, 0);
		wr(8'hBA, 8'h02);
		ticks(1032, 2, 1);
		wr(8'hD8, 8'h00);
		ticks(200, 0, 1);
		wrap_up();
	end
endmodule // testbench
bind sbrg_baud_gen sbrg_chk chk_u (
	.clk_sys_i            (clk_sys_i),
	.rst_b_i              (rst_b_i),
	.addr_i               (addr_i),
	.wdata_i              (wdata_i),
	.wr_i                 (wr_i),
	.rd_i                 (rd_i),
	.rdata_o              (rdata_o),
	.tick16_o             (tick16_o),
	.baud_source_select_o (baud_source_select_o),
	.gen_overflow_o       (gen_overflow_o)
);
